// ===== rtl/csr_bridge_pkg.sv
// Constants, field layouts and types shared by the switch CSR bridge.
// Assumes byte addresses on a 32-bit APB with 12 address bits.
package csr_bridge_pkg;

  // Host byte offsets
  localparam logic [11:0] OFS_PORT1_CFG  = 12'h1A0;
  localparam logic [11:0] OFS_PORT2_CFG  = 12'h1A4;
  localparam logic [11:0] OFS_PORT0_CFG  = 12'h1A8;
  localparam logic [11:0] OFS_VALUE      = 12'h1AC;
  localparam logic [11:0] OFS_COMMAND    = 12'h1B0;
  localparam logic [11:0] OFS_SRC_HIGH   = 12'h1F0;
  localparam logic [11:0] OFS_SRC_LOW    = 12'h1F4;
  localparam logic [11:0] OFS_WIN_FIRST  = 12'h200;
  localparam logic [11:0] OFS_WIN_LAST   = 12'h2F8;

  // Command register fields
  localparam int CMD_PENDING_BIT  = 31;
  localparam int CMD_DIR_BIT      = 30;
  localparam int CMD_STEP_UP_BIT  = 29;
  localparam int CMD_STEP_DN_BIT  = 28;
  localparam int CMD_LANES_LSB    = 16;
  localparam int CMD_LOC_LSB      = 0;

  // Port pause configuration fields
  localparam int PCFG_JAM_BIT     = 6;
  localparam int PCFG_DUPLEX_BIT  = 5;
  localparam int PCFG_RX_ACT_BIT  = 4;
  localparam int PCFG_TX_ACT_BIT  = 3;
  localparam int PCFG_RX_EN_BIT   = 2;
  localparam int PCFG_TX_EN_BIT   = 1;
  localparam int PCFG_MANUAL_BIT  = 0;

  // Values after reset, and the lane mask for window writes
  localparam logic [31:0] RST_VALUE      = 32'h0000_0000;
  localparam logic [15:0] RST_LOC        = 16'h0000;
  localparam logic [3:0]  RST_LANES      = 4'h0;
  localparam logic [3:0]  ALL_LANES      = 4'hF;
  localparam logic [15:0] RST_SRC_HIGH   = 16'h0000;
  localparam logic [31:0] RST_SRC_LOW    = 32'h0000_0000;
  localparam logic [2:0]  RST_JAM        = 3'h0;
  localparam logic [2:0]  RST_RX_EN      = 3'h0;
  localparam logic [2:0]  RST_TX_EN      = 3'h0;
  localparam logic [2:0]  RST_MANUAL     = 3'h0;

  // Direct window mapping: fabric location of the first window word
  localparam logic [15:0] WIN_LOC_BASE   = 16'h0000;

  // Number of switch ports
  localparam int PORT_COUNT = 3;

  // Transfer sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } xfer_state_e;

endpackage

// ===== rtl/pause_port_ctrl.sv
// Resolves the pause and backpressure enables in effect for one port.
// Assumes negotiation status and abilities are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pause_port_ctrl (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic an_enable,
  input  wire logic an_complete,
  input  wire logic half_duplex,
  input  wire logic local_pause,
  input  wire logic local_asym,
  input  wire logic partner_pause,
  input  wire logic partner_asym,
  input  wire logic manual_select,
  input  wire logic pause_rx_enable,
  input  wire logic pause_tx_enable,
  input  wire logic half_duplex_jam_enable,
  output logic      rx_active,
  output logic      tx_active
);

  typedef struct packed {
    logic rx;
    logic tx;
  } pstate_s;

  pstate_s state_reg;
  pstate_s state_next;

  // Pick manual or negotiated enables per duplex
  always_comb begin
    state_next = state_reg;
    if (half_duplex) begin
      state_next.rx = 1'b0;
      state_next.tx = half_duplex_jam_enable;
    end else if (manual_select || !an_enable) begin
      state_next.rx = pause_rx_enable;
      state_next.tx = pause_tx_enable;
    end else if (!an_complete) begin
      state_next.rx = 1'b0;
      state_next.tx = 1'b0;
    end else begin
      state_next.rx = (local_pause && partner_pause) ||
                      (local_pause && local_asym && !partner_pause && partner_asym);
      state_next.tx = (local_pause && partner_pause) ||
                      (!local_pause && local_asym && partner_pause && partner_asym);
    end
    if (sys_rst) begin
      state_next = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  assign rx_active = state_reg.rx;
  assign tx_active = state_reg.tx;

endmodule
`default_nettype wire

// ===== rtl/switch_indirect_csr_access.sv
// APB-reached bridge into the switch fabric's indirect registers, plus
// the pause source address and per-port pause configuration registers.
// Assumes the fabric holds fab_ack for one cycle per request.
//
// Overview of operation
// - Command with pending, write direction starts write.
// - Pending clears when fabric write completes.
// - Stepped write: each value write launches write.
// - Stepped write completion clears pending, steps address.
// - Window write loads location, lanes, write, pending.
// - Window spans 200h to 2F8h, maps subset.
// - Command with pending, read direction starts read.
// - Fetched value stored in the same cycle pending clears.
// - Stepped read starts from command with step.
// - Value read in stepped read steps, relaunches.
// - Value at 1ACh, command at 1B0h.
// - Pause source address at 1F0h and 1F4h.
// - Bit 6 enables half-duplex backpressure.
// - Bit 5 shows duplex, 1 is half.
// - Bits 4 and 3 show pause enables.
// - Bit 2 enables pause reception manually.
// - Bit 1 enables pause generation manually.
// - Register reads back enables in effect.
// - Writes never touch advertised pause abilities.
// - Bit 0 selects manual or negotiated control.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module switch_indirect_csr_access
  import csr_bridge_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fabric register port
  output logic             fab_req,
  output logic             fab_write,
  output logic      [15:0] fab_addr,
  output logic      [3:0]  fab_lanes,
  output logic      [31:0] fab_wdata,
  input  wire logic        fab_ack,
  input  wire logic [31:0] fab_rdata,
  // Port status, index is port number
  input  wire logic [2:0]  an_enable,
  input  wire logic [2:0]  an_complete,
  input  wire logic [2:0]  present_duplex,
  input  wire logic [2:0]  local_pause,
  input  wire logic [2:0]  local_asym,
  input  wire logic [2:0]  partner_pause,
  input  wire logic [2:0]  partner_asym,
  // Port controls toward the fabric
  output logic      [2:0]  half_duplex_jam_enable,
  output logic      [2:0]  present_pause_rx_state,
  output logic      [2:0]  present_pause_tx_state,
  output logic      [47:0] pause_source_addr
);

  typedef struct packed {
    xfer_state_e xfer;
    logic [31:0] value;
    logic        transfer_pending;
    logic        direction_select;
    logic        address_step_up;
    logic        address_step_down;
    logic [3:0]  lane_enables;
    logic [15:0] target_location;
    logic [15:0] src_high;
    logic [31:0] src_low;
    logic [2:0]  jam_en;
    logic [2:0]  rx_en;
    logic [2:0]  tx_en;
    logic [2:0]  manual;
    logic [31:0] rdata;
    logic        err;
  } state_s;

  state_s      state_reg;
  state_s      state_next;
  logic [15:0] window_loc;
  logic [2:0]  rx_active;
  logic [2:0]  tx_active;
  logic        setup_phase;
  logic        access_phase;
  logic        in_window;
  logic        stepping;
  logic [31:0] read_mux;
  logic        mapped;
  logic [1:0]  port_sel;
  logic        is_port_cfg;

  // Window offset to fabric location
  window_map u_window_map (
    .host_offset (paddr),
    .fabric_loc  (window_loc)
  );

  // Per-port pause resolution
  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port
      pause_port_ctrl u_port (
        .sys_clk                (sys_clk),
        .sys_rst                (sys_rst),
        .an_enable              (an_enable[gp]),
        .an_complete            (an_complete[gp]),
        .half_duplex            (present_duplex[gp]),
        .local_pause            (local_pause[gp]),
        .local_asym             (local_asym[gp]),
        .partner_pause          (partner_pause[gp]),
        .partner_asym           (partner_asym[gp]),
        .manual_select          (state_reg.manual[gp]),
        .pause_rx_enable        (state_reg.rx_en[gp]),
        .pause_tx_enable        (state_reg.tx_en[gp]),
        .half_duplex_jam_enable (state_reg.jam_en[gp]),
        .rx_active              (rx_active[gp]),
        .tx_active              (tx_active[gp])
      );
    end
  endgenerate

  // Bus phases and decode
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign in_window    = (paddr >= OFS_WIN_FIRST) && (paddr <= OFS_WIN_LAST)
                        && (paddr[1:0] == 2'b00);
  assign stepping     = state_reg.address_step_up || state_reg.address_step_down;

  // Port index and read data selection
  always_comb begin
    read_mux    = 32'h0000_0000;
    mapped      = 1'b1;
    port_sel    = 2'h0;
    is_port_cfg = 1'b0;
    case (paddr)
      OFS_PORT1_CFG: begin
        port_sel    = 2'h1;
        is_port_cfg = 1'b1;
      end
      OFS_PORT2_CFG: begin
        port_sel    = 2'h2;
        is_port_cfg = 1'b1;
      end
      OFS_PORT0_CFG: begin
        port_sel    = 2'h0;
        is_port_cfg = 1'b1;
      end
      OFS_VALUE: begin
        read_mux = state_reg.value;
      end
      OFS_COMMAND: begin
        read_mux[CMD_PENDING_BIT]                  = state_reg.transfer_pending;
        read_mux[CMD_DIR_BIT]                      = state_reg.direction_select;
        read_mux[CMD_STEP_UP_BIT]                  = state_reg.address_step_up;
        read_mux[CMD_STEP_DN_BIT]                  = state_reg.address_step_down;
        read_mux[CMD_LANES_LSB +: 4]               = state_reg.lane_enables;
        read_mux[CMD_LOC_LSB +: 16]                = state_reg.target_location;
      end
      OFS_SRC_HIGH: begin
        read_mux[15:0] = state_reg.src_high;
      end
      OFS_SRC_LOW: begin
        read_mux = state_reg.src_low;
      end
      default: begin
        mapped = in_window;
      end
    endcase
    if (is_port_cfg) begin
      read_mux[PCFG_JAM_BIT]    = state_reg.jam_en[port_sel];
      read_mux[PCFG_DUPLEX_BIT] = present_duplex[port_sel];
      read_mux[PCFG_RX_ACT_BIT] = rx_active[port_sel];
      read_mux[PCFG_TX_ACT_BIT] = tx_active[port_sel];
      read_mux[PCFG_RX_EN_BIT]  = state_reg.rx_en[port_sel];
      read_mux[PCFG_TX_EN_BIT]  = state_reg.tx_en[port_sel];
      read_mux[PCFG_MANUAL_BIT] = state_reg.manual[port_sel];
    end
  end

  // Register updates, transfer launch and completion
  always_comb begin
    state_next = state_reg;

    // Capture read data and error in the setup phase
    if (setup_phase) begin
      state_next.rdata = pwrite ? 32'h0000_0000 : read_mux;
      state_next.err   = !mapped;
    end

    // Completion from the fabric
    if (state_reg.xfer == ST_BUSY && fab_ack) begin
      state_next.xfer             = ST_IDLE;
      state_next.transfer_pending = 1'b0;
      if (state_reg.direction_select) begin
        state_next.value = fab_rdata;
      end else if (state_reg.address_step_up) begin
        state_next.target_location = state_reg.target_location + 16'h0001;
      end else if (state_reg.address_step_down) begin
        state_next.target_location = state_reg.target_location - 16'h0001;
      end
    end

    // Host accesses take effect at the access edge
    if (access_phase && pwrite && mapped) begin
      if (is_port_cfg) begin
        state_next.jam_en[port_sel] = pwdata[PCFG_JAM_BIT];
        state_next.rx_en[port_sel]  = pwdata[PCFG_RX_EN_BIT];
        state_next.tx_en[port_sel]  = pwdata[PCFG_TX_EN_BIT];
        state_next.manual[port_sel] = pwdata[PCFG_MANUAL_BIT];
      end else if (paddr == OFS_SRC_HIGH) begin
        state_next.src_high = pwdata[15:0];
      end else if (paddr == OFS_SRC_LOW) begin
        state_next.src_low = pwdata;
      end else if (!state_reg.transfer_pending) begin
        // Writes to the indirect path are ignored while a transfer runs
        if (paddr == OFS_COMMAND) begin
          state_next.direction_select  = pwdata[CMD_DIR_BIT];
          state_next.address_step_up   = pwdata[CMD_STEP_UP_BIT];
          state_next.address_step_down = pwdata[CMD_STEP_DN_BIT];
          state_next.lane_enables      = pwdata[CMD_LANES_LSB +: 4];
          state_next.target_location   = pwdata[CMD_LOC_LSB +: 16];
          if (pwdata[CMD_PENDING_BIT]) begin
            state_next.transfer_pending = 1'b1;
            state_next.xfer             = ST_BUSY;
          end
        end else if (paddr == OFS_VALUE) begin
          state_next.value = pwdata;
          if (stepping && !state_reg.direction_select) begin
            state_next.transfer_pending = 1'b1;
            state_next.xfer             = ST_BUSY;
          end
        end else if (in_window) begin
          state_next.value            = pwdata;
          state_next.target_location  = window_loc;
          state_next.lane_enables     = ALL_LANES;
          state_next.direction_select = 1'b0;
          state_next.transfer_pending = 1'b1;
          state_next.xfer             = ST_BUSY;
        end
      end
    end

    // Stepped read: a value read steps the address and relaunches
    if (access_phase && !pwrite && paddr == OFS_VALUE && !state_reg.transfer_pending
        && state_reg.direction_select && stepping) begin
      if (state_reg.address_step_up) begin
        state_next.target_location = state_reg.target_location + 16'h0001;
      end else begin
        state_next.target_location = state_reg.target_location - 16'h0001;
      end
      state_next.transfer_pending = 1'b1;
      state_next.xfer             = ST_BUSY;
    end

    // Synchronous reset
    if (sys_rst) begin
      state_next                   = '0;
      state_next.xfer              = ST_IDLE;
      state_next.value             = RST_VALUE;
      state_next.lane_enables      = RST_LANES;
      state_next.target_location   = RST_LOC;
      state_next.src_high          = RST_SRC_HIGH;
      state_next.src_low           = RST_SRC_LOW;
      state_next.jam_en            = RST_JAM;
      state_next.rx_en             = RST_RX_EN;
      state_next.tx_en             = RST_TX_EN;
      state_next.manual            = RST_MANUAL;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // Bus answers: one access cycle, data registered in setup
  assign pready  = access_phase;
  assign prdata  = state_reg.rdata;
  assign pslverr = access_phase && state_reg.err;

  // Fabric request held from registers until acknowledged
  assign fab_req   = (state_reg.xfer == ST_BUSY);
  assign fab_write = !state_reg.direction_select;
  assign fab_addr  = state_reg.target_location;
  assign fab_lanes = state_reg.lane_enables;
  assign fab_wdata = state_reg.value;

  // Port control outputs
  assign half_duplex_jam_enable = state_reg.jam_en;
  assign present_pause_rx_state = rx_active;
  assign present_pause_tx_state = tx_active;
  assign pause_source_addr      = {state_reg.src_high, state_reg.src_low};

endmodule
`default_nettype wire

// ===== rtl/window_map.sv
// Maps a direct-window host offset to a fabric register location.
// Assumes the caller has already checked the offset lies in the window.
`timescale 1ns/1ps
`default_nettype none
module window_map
  import csr_bridge_pkg::*;
(
  input  wire logic [11:0] host_offset,
  output logic      [15:0] fabric_loc
);

  logic [5:0] word_index;

  // Word index inside the window, offset onto the mapped fabric range
  always_comb begin
    word_index = 6'((host_offset - OFS_WIN_FIRST) >> 2);
    fabric_loc = WIN_LOC_BASE + {10'h000, word_index};
  end

endmodule
`default_nettype wire

// ===== tb/csr_bridge_sva.sv
// Assertions on the CSR bridge top ports: launches, window, fabric handshake.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module csr_bridge_sva
  import csr_bridge_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fab_req,
  input wire logic        fab_write,
  input wire logic [15:0] fab_addr,
  input wire logic [3:0]  fab_lanes,
  input wire logic [31:0] fab_wdata,
  input wire logic        fab_ack,
  input wire logic [47:0] pause_source_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Access phase and window decode helpers
  wire logic acc = psel && penable;
  wire logic in_win = paddr >= OFS_WIN_FIRST && paddr <= OFS_WIN_LAST;
  // Host writes that start a fabric transfer while idle
  sequence s_cmd_go;
    acc && pwrite && paddr == OFS_COMMAND && pwdata[CMD_PENDING_BIT] && !fab_req;
  endsequence
  sequence s_win_go;
    acc && pwrite && in_win && paddr[1:0] == 2'h0 && !fab_req;
  endsequence
  property p_launch;
    s_cmd_go |=> fab_req && fab_addr == $past(pwdata[15:0])
      && fab_write == !$past(pwdata[CMD_DIR_BIT])
      && ($past(pwdata[CMD_DIR_BIT]) || fab_lanes == $past(pwdata[19:16]));
  endproperty
  a_launch: assert property (p_launch) else $error("command launch wrong");
  property p_window;
    s_win_go |=> fab_req && fab_write && fab_lanes == ALL_LANES && fab_wdata == $past(pwdata)
      && fab_addr == WIN_LOC_BASE + 16'(($past(paddr) - OFS_WIN_FIRST) >> 2);
  endproperty
  a_window: assert property (p_window) else $error("window launch wrong");
  property p_hold;
    fab_req && !fab_ack |=> fab_req && $stable(fab_addr) && $stable(fab_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_drop;
    fab_req && fab_ack |=> !fab_req;
  endproperty
  a_drop: assert property (p_drop) else $error("request held after ack");
  property p_ready;
    psel |-> pready == penable;
  endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  property p_decode;
    acc && in_win |-> pslverr == (paddr[1:0] != 2'h0);
  endproperty
  a_decode: assert property (p_decode) else $error("window decode wrong");
  property p_pending;
    psel && !penable && !pwrite && paddr == OFS_COMMAND
      |=> prdata[CMD_PENDING_BIT] == $past(fab_req);
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag wrong");
  property p_src;
    acc && pwrite && paddr == OFS_SRC_LOW |=> pause_source_addr[31:0] == $past(pwdata);
  endproperty
  a_src: assert property (p_src) else $error("pause source wrong");
endmodule

bind switch_indirect_csr_access csr_bridge_sva u_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fab_req(fab_req), .fab_write(fab_write), .fab_addr(fab_addr), .fab_lanes(fab_lanes),
  .fab_wdata(fab_wdata), .fab_ack(fab_ack), .pause_source_addr(pause_source_addr)
);
`default_nettype wire

// ===== tb/fabric_model.sv
// Behavioural fabric register store that answers the bridge's requests.
// Assumes one request at a time; delay sets how long the answer takes.
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        fab_req,
  input  wire logic        fab_write,
  input  wire logic [15:0] fab_addr,
  input  wire logic [3:0]  fab_lanes,
  input  wire logic [31:0] fab_wdata,
  input  wire logic [3:0]  delay,
  output logic             fab_ack,
  output logic      [31:0] fab_rdata
);
  logic [31:0] mem [logic [15:0]];
  logic [31:0] cur;
  int          waited;
  initial begin
    fab_ack = 1'b0;
    fab_rdata = 32'h0;
    waited = 0;
  end
  // Answer after the wait; read data is only meaningful with the ack
  always @(posedge sys_clk) begin
    fab_ack <= 1'b0;
    fab_rdata <= ~fab_rdata;
    if (sys_rst || !fab_req || fab_ack) begin
      waited <= 0;
    end else if (waited < delay) begin
      waited <= waited + 1;
    end else begin
      cur = mem.exists(fab_addr) ? mem[fab_addr] : {~fab_addr, fab_addr};
      if (fab_write) begin
        for (int b = 0; b < 4; b++)
          if (fab_lanes[b]) cur[8*b +: 8] = fab_wdata[8*b +: 8];
        mem[fab_addr] = cur;
      end
      fab_rdata <= cur;
      fab_ack <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/switch_indirect_csr_access_tb_top.sv
// Testbench for the switch CSR bridge: APB tasks, fabric model, port cases.
// Assumes the bridge answers APB with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module switch_indirect_csr_access_tb_top
  import csr_bridge_pkg::*;
;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        fab_req, fab_write, fab_ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fab_wdata, fab_rdata, r;
  logic [15:0] fab_addr;
  logic [3:0]  fab_lanes, dly;
  logic [2:0]  an_en, an_cp, dup, lp, la, pp, pa, jam, rx_st, tx_st;
  logic [47:0] src;
  int          mismatches, check_count;
  // Port cases: {an_en, an_done, half, lp, la, pp, pa}, written, read back
  localparam logic [22:0] PC [8] = '{{7'h00, 8'hFF, 8'h5F}, {7'h00, 8'h04, 8'h14},
    {7'h6A, 8'h06, 8'h1E}, {7'h67, 8'h06, 8'h0E}, {7'h6D, 8'h06, 8'h16},
    {7'h70, 8'h46, 8'h6E}, {7'h40, 8'h06, 8'h06}, {7'h60, 8'h07, 8'h1F}};
  localparam logic [11:0] PO [3] = '{OFS_PORT0_CFG, OFS_PORT1_CFG, OFS_PORT2_CFG};
  localparam logic [11:0] RA [7] = '{OFS_PORT1_CFG, OFS_PORT2_CFG, OFS_PORT0_CFG, OFS_VALUE,
    OFS_COMMAND, OFS_SRC_HIGH, OFS_SRC_LOW};

  switch_indirect_csr_access DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fab_req(fab_req), .fab_write(fab_write), .fab_addr(fab_addr), .fab_lanes(fab_lanes),
    .fab_wdata(fab_wdata), .fab_ack(fab_ack), .fab_rdata(fab_rdata), .an_enable(an_en),
    .an_complete(an_cp), .present_duplex(dup), .local_pause(lp), .local_asym(la),
    .partner_pause(pp), .partner_asym(pa), .half_duplex_jam_enable(jam),
    .present_pause_rx_state(rx_st), .present_pause_tx_state(tx_st), .pause_source_addr(src));

  fabric_model u_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .fab_req(fab_req), .fab_write(fab_write),
    .fab_addr(fab_addr), .fab_lanes(fab_lanes), .fab_wdata(fab_wdata), .delay(dly),
    .fab_ack(fab_ack), .fab_rdata(fab_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Value comparison
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; result taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Poll the pending flag, bounded
  task automatic wait_done;
    int n;
    n = 0;
    r = 32'hFFFF_FFFF;
    while (r[CMD_PENDING_BIT] !== 1'b0 && n < 100) begin
      apb(1'b0, OFS_COMMAND, 32'h0);
      n++;
    end
    if (n >= 100) mismatches++;
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    mismatches++;
    conclude;
  end

  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, dly} = {1'b1, 51'h0};
    {an_en, an_cp, dup, lp, la, pp, pa} = 21'h0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (RA[i]) rd(RA[i], 32'h0);
    $display("reset values done");
    apb(1'b1, OFS_VALUE, 32'h1234_5678);
    apb(1'b1, OFS_COMMAND, 32'h800F_0010);
    wait_done;
    apb(1'b1, OFS_VALUE, 32'hAABB_CCDD);
    apb(1'b1, OFS_COMMAND, 32'h8003_0010);
    wait_done;
    apb(1'b1, OFS_COMMAND, 32'hC000_0010);
    wait_done;
    rd(OFS_VALUE, 32'h1234_CCDD);
    rd(OFS_COMMAND, 32'h4000_0010);
    dly <= 4'hC;
    apb(1'b1, OFS_COMMAND, 32'hC000_0055);
    apb(1'b1, OFS_VALUE, 32'h0BAD_0BAD);
    apb(1'b1, OFS_COMMAND, 32'h800F_0066);
    wait_done;
    rd(OFS_VALUE, 32'hFFAA_0055);
    rd(OFS_COMMAND, 32'h4000_0055);
    dly <= 4'h0;
    $display("single transfers done");
    apb(1'b1, OFS_COMMAND, 32'h200F_0020);
    apb(1'b1, OFS_VALUE, 32'hD000_0000);
    wait_done;
    apb(1'b1, OFS_VALUE, 32'hD000_0001);
    wait_done;
    rd(OFS_COMMAND, 32'h200F_0022);
    apb(1'b1, OFS_COMMAND, 32'h100F_0031);
    apb(1'b1, OFS_VALUE, 32'hD000_0031);
    wait_done;
    rd(OFS_COMMAND, 32'h100F_0030);
    apb(1'b1, OFS_COMMAND, 32'hE000_0020);
    wait_done;
    rd(OFS_VALUE, 32'hD000_0000);
    wait_done;
    apb(1'b1, OFS_COMMAND, 32'h4000_0021);
    rd(OFS_VALUE, 32'hD000_0001);
    rd(OFS_COMMAND, 32'h4000_0021);
    $display("stepped transfers done");
    apb(1'b1, OFS_WIN_FIRST + 12'h008, 32'hCAFE_0001);
    wait_done;
    rd(OFS_COMMAND, {12'h000, ALL_LANES, WIN_LOC_BASE + 16'h0002});
    apb(1'b1, OFS_WIN_LAST, 32'hCAFE_003E);
    wait_done;
    apb(1'b1, OFS_COMMAND, {16'hC000, WIN_LOC_BASE + 16'h0002});
    wait_done;
    rd(OFS_VALUE, 32'hCAFE_0001);
    apb(1'b1, 12'h2FC, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h202, 32'h0);
    chk(err, 1'b1);
    $display("window done");
    apb(1'b1, OFS_SRC_HIGH, 32'h0000_ABCD);
    apb(1'b1, OFS_SRC_LOW, 32'h1234_5678);
    // Let the write edge settle before looking at the output
    @(posedge sys_clk);
    chk(src, 48'hABCD_1234_5678);
    rd(OFS_SRC_HIGH, 32'h0000_ABCD);
    rd(OFS_SRC_LOW, 32'h1234_5678);
    $display("pause source done");
    foreach (PC[c]) begin
      {an_en, an_cp, dup} <= {{3{PC[c][22]}}, {3{PC[c][21]}}, {3{PC[c][20]}}};
      {lp, la, pp, pa} <= {{3{PC[c][19]}}, {3{PC[c][18]}}, {3{PC[c][17]}}, {3{PC[c][16]}}};
      for (int p = 0; p < 3; p++) begin
        apb(1'b1, PO[p], {{24{PC[c][15]}}, PC[c][15:8]});
        rd(PO[p], {24'h0, PC[c][7:0]});
        chk({jam[p], rx_st[p], tx_st[p]}, {PC[c][14], PC[c][4], PC[c][3]});
      end
    end
    $display("port pause cases done");
    conclude;
  end
endmodule
`default_nettype wire
